// File: rtl/vcr_defines.vh
// Constants for the VC resource 0 capability register bank and its diagnostic registers.
`ifndef VCR_DEFINES_VH
`define VCR_DEFINES_VH

// Byte addresses of the registers on the AHB-Lite bus.
`define VCR_ADDR_CAP 32'h00000210
`define VCR_ADDR_DIAG_CTRL 32'h00000300
`define VCR_ADDR_DIAG_STATUS 32'h00000304
`define VCR_ADDR_DIAG_LAST 32'h00000308

// Capability field positions.
`define VCR_PARB_LSB 0
`define VCR_PARB_MSB 7
`define VCR_RSVD_LO_LSB 8
`define VCR_RSVD_LO_MSB 13
`define VCR_ADV_SW_BIT 14
`define VCR_SNOOP_REJ_BIT 15
`define VCR_TSLOT_LSB 16
`define VCR_TSLOT_MSB 22
`define VCR_RSVD_HI_BIT 23
`define VCR_TBLOFF_LSB 24
`define VCR_TBLOFF_MSB 31

// Arbitration scheme bit numbers inside the capability field.
`define VCR_ARB_FIXED_RR 0
`define VCR_ARB_WRR32 1
`define VCR_ARB_WRR64 2
`define VCR_ARB_WRR128 3
`define VCR_ARB_TWRR128 4
`define VCR_ARB_WRR256 5

// Fixed field values per port role.
`define VCR_PARB_UP 8'h03
`define VCR_PARB_DOWN 8'h01
`define VCR_TBLOFF_UP 8'h02
`define VCR_TBLOFF_DOWN 8'h00
`define VCR_ADV_SW_VAL 1'h0
`define VCR_SNOOP_REJ_VAL 1'h0
`define VCR_TSLOT_VAL 7'h00

// Diagnostic control fields and reset values.
`define VCR_CTRL_CLEAR_BIT 0
`define VCR_CTRL_COUNT_EN_BIT 1
`define VCR_CTRL_COUNT_EN_RST 1'h1

// Diagnostic status fields.
`define VCR_STS_IGNORED_BIT 0
`define VCR_STS_ROLE_BIT 1
`define VCR_STS_UNMAPPED_BIT 2
`define VCR_STS_LOCKED_BIT 3
`define VCR_STS_CNT_LSB 8
`define VCR_STS_CNT_MSB 15
`define VCR_CNT_MAX 8'hff

// Settle count at which the role strap is frozen, on the fourth cycle after reset release.
`define VCR_ROLE_SETTLE 2'h3

// AHB encodings.
`define VCR_HSIZE_WORD 3'h2
`define VCR_HRESP_OKAY 1'h0

`endif

// File: rtl/vcr_ahb_front.v
// AHB-Lite address-phase decode and data-phase write capture for the capability bank.
`timescale 1ns/1ps
`include "vcr_defines.vh"

module vcr_ahb_front
(
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // AHB-Lite address phase
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   // Decoded read request, valid in the address phase
   output wire rd_en,
   output wire [31:0] rd_addr,
   // Write request, valid in the data phase beside hwdata
   output reg wr_en,
   output reg [31:0] wr_addr,
   output reg wr_word_ok
);

   wire addr_phase;

   // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
   assign addr_phase = hsel & htrans[1] & hready;
   assign rd_en = addr_phase & ~hwrite;
   assign rd_addr = haddr;

   // Writes are held one cycle so that hwdata can be used in the data phase.
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         wr_en <= 1'b0;
         wr_addr <= 32'h00000000;
         wr_word_ok <= 1'b0;
      end
      else
      begin
         wr_en <= addr_phase & hwrite;
         if (addr_phase & hwrite)
         begin
            wr_addr <= haddr;
            wr_word_ok <= (hsize == `VCR_HSIZE_WORD) && (haddr[1:0] == 2'h0);
         end
      end
   end

endmodule

// File: rtl/vcr_cap_word.v
// Builds the fixed capability word from the port role.
`timescale 1ns/1ps
`include "vcr_defines.vh"

module vcr_cap_word
(
   // Port role, high on the upstream port
   input wire is_upstream,
   // Capability word
   output wire [31:0] cap_word
);

   wire [31:0] up_word;
   wire [31:0] down_word;
   genvar i;

   // Both role images are constants, so each bit reduces to a wire or a tie.
   assign up_word = {`VCR_TBLOFF_UP, 1'b0, `VCR_TSLOT_VAL, `VCR_SNOOP_REJ_VAL, `VCR_ADV_SW_VAL,
                     6'h00, `VCR_PARB_UP};
   assign down_word = {`VCR_TBLOFF_DOWN, 1'b0, `VCR_TSLOT_VAL, `VCR_SNOOP_REJ_VAL,
                       `VCR_ADV_SW_VAL, 6'h00, `VCR_PARB_DOWN};

   // Per-bit selection between the upstream and downstream images.
   generate
      for (i = 0; i < 32; i = i + 1)
      begin : g_bit
         assign cap_word[i] = is_upstream ? up_word[i] : down_word[i];
      end
   endgenerate

endmodule

// File: rtl/vcr_cap_regs.v
// Top of the VC resource 0 capability register bank with an AHB-Lite slave port.
//
// Function
// - On the upstream port the arbitration capability field in bits 7 to 0 reads 0x3 and is read-only.
// - On a downstream port the arbitration capability field reads 0x1, fixed round robin only.
// - Each capability bit names one scheme, bit 0 fixed round robin up to bit 5 for 256 phases.
// - Bit 14, advanced packet switching, always reads zero.
// - Bit 15, snoop rejection, always reads zero.
// - The maximum time slots field in bits 22 to 16 always reads zero.
// - Bits 31 to 24 hold the arbitration table offset in 16-byte units from the structure base.
// - The table offset reads 0x2 on the upstream port and 0x0 on a downstream port.
//
// The port role comes from a strap pin. It is synchronised, followed for a few
// cycles after reset release and then frozen, so a glitch on the pin later in
// operation cannot change what configuration software has already read.
//
// Beside the capability word the bank offers three diagnostic registers: a
// control word that clears the status and gates the counter, a status word
// with sticky flags, the role and a count of dropped writes, and the address
// of the most recent dropped write or unmapped read.
`timescale 1ns/1ps
`include "vcr_defines.vh"

module vcr_cap_regs
(
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Port role strap, high on the upstream port
   input wire port_upstream_pin,
   // AHB-Lite slave inputs
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   // AHB-Lite slave outputs
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp
);

   // Strap synchroniser and role capture.
   reg strap_meta;
   reg strap_sync;
   reg [1:0] settle_cnt;
   reg role_locked;
   reg port_is_upstream;

   // Diagnostic state.
   reg count_en;
   reg ignored_seen;
   reg unmapped_seen;
   reg [7:0] ignored_cnt;
   reg [31:0] last_addr;

   // Bus front end.
   wire rd_en;
   wire [31:0] rd_addr;
   wire wr_en;
   wire [31:0] wr_addr;
   wire wr_word_ok;

   // Capability word and decode terms.
   wire [31:0] cap_word;
   wire wr_ctrl;
   wire clear_req;
   wire ignored_evt;
   wire wr_unmapped;
   wire rd_unmapped;
   wire unmapped_evt;
   reg [31:0] next_rdata;
   reg [7:0] next_cnt;

   // Address decode and write capture.
   vcr_ahb_front u_front
   (
      .core_clk (core_clk),
      .resetn (resetn),
      .hsel (hsel),
      .haddr (haddr),
      .htrans (htrans),
      .hwrite (hwrite),
      .hsize (hsize),
      .hready (hready),
      .rd_en (rd_en),
      .rd_addr (rd_addr),
      .wr_en (wr_en),
      .wr_addr (wr_addr),
      .wr_word_ok (wr_word_ok)
   );

   // Fixed capability image for the captured role.
   vcr_cap_word u_cap
   (
      .is_upstream (port_is_upstream),
      .cap_word (cap_word)
   );

   // Two flip-flops bring the strap pin into the core clock domain.
   // The first stage may go metastable, so only the second stage is read
   // by any logic.
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end
      else
      begin
         strap_meta <= port_upstream_pin;
         strap_sync <= strap_meta;
      end
   end

   // The role follows the synchronised strap until the settle count runs out,
   // then it is frozen; until then the bank reports the image of the synchronised strap.
   // A strap that changes after the lock is ignored until the next reset.
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         settle_cnt <= 2'h0;
         role_locked <= 1'b0;
         port_is_upstream <= 1'b0;
      end
      else if (!role_locked)
      begin
         port_is_upstream <= strap_sync;
         if (settle_cnt == `VCR_ROLE_SETTLE)
         begin
            role_locked <= 1'b1;
         end
         else
         begin
            settle_cnt <= settle_cnt + 2'h1;
         end
      end
   end

   // Write decode. Only the control register accepts data; everything else
   // is read-only or unmapped and the write is dropped and noted.
   // Writes act one cycle late, in the data phase, because hwdata only stands there.
   assign wr_ctrl = wr_en && (wr_addr == `VCR_ADDR_DIAG_CTRL) && wr_word_ok;
   assign clear_req = wr_ctrl && hwdata[`VCR_CTRL_CLEAR_BIT];
   assign ignored_evt = wr_en && !wr_ctrl;
   assign wr_unmapped = wr_en && (wr_addr != `VCR_ADDR_CAP) &&
                        (wr_addr != `VCR_ADDR_DIAG_CTRL) &&
                        (wr_addr != `VCR_ADDR_DIAG_STATUS) &&
                        (wr_addr != `VCR_ADDR_DIAG_LAST);
   assign rd_unmapped = rd_en && (rd_addr != `VCR_ADDR_CAP) &&
                        (rd_addr != `VCR_ADDR_DIAG_CTRL) &&
                        (rd_addr != `VCR_ADDR_DIAG_STATUS) &&
                        (rd_addr != `VCR_ADDR_DIAG_LAST);
   assign unmapped_evt = wr_unmapped | rd_unmapped;

   // Counting enable is the one software-steered setting in the bank.
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         count_en <= `VCR_CTRL_COUNT_EN_RST;
      end
      else if (wr_ctrl)
      begin
         count_en <= hwdata[`VCR_CTRL_COUNT_EN_BIT];
      end
   end

   // Next ignored-write count: a clear restarts it, but an event in the same
   // cycle still counts, so no ignored write is ever lost to a clear.
   // The count saturates instead of wrapping, so a long burst of dropped
   // writes can never read back as a small number.
   always @*
   begin
      next_cnt = ignored_cnt;
      if (clear_req)
      begin
         next_cnt = (ignored_evt && count_en) ? 8'h01 : 8'h00;
      end
      else if (ignored_evt && count_en && (ignored_cnt != `VCR_CNT_MAX))
      begin
         next_cnt = ignored_cnt + 8'h01;
      end
   end

   // Sticky flags; a setting event beats a clear that lands in the same cycle.
   // An unmapped read is seen in its address phase, a dropped write in its
   // data phase, so both may arrive together and both are kept.
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         ignored_seen <= 1'b0;
         unmapped_seen <= 1'b0;
         ignored_cnt <= 8'h00;
      end
      else
      begin
         ignored_cnt <= next_cnt;
         if (ignored_evt)
         begin
            ignored_seen <= 1'b1;
         end
         else if (clear_req)
         begin
            ignored_seen <= 1'b0;
         end
         if (unmapped_evt)
         begin
            unmapped_seen <= 1'b1;
         end
         else if (clear_req)
         begin
            unmapped_seen <= 1'b0;
         end
      end
   end

   // Address of the most recent dropped write or unmapped read; a write in its
   // data phase is older than a read in its address phase, so the read wins.
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         last_addr <= 32'h00000000;
      end
      else if (rd_unmapped)
      begin
         last_addr <= rd_addr;
      end
      else if (ignored_evt)
      begin
         last_addr <= wr_addr;
      end
   end

   // Read multiplexer. Reserved and unmapped bits return zero.
   // A capability read taken inside the settle window may still show the
   // downstream image; software is expected to wait for the lock flag.
   always @*
   begin
      next_rdata = 32'h00000000;
      case (rd_addr)
         `VCR_ADDR_CAP:
         begin
            next_rdata = cap_word;
         end
         `VCR_ADDR_DIAG_CTRL:
         begin
            next_rdata[`VCR_CTRL_COUNT_EN_BIT] = count_en;
         end
         `VCR_ADDR_DIAG_STATUS:
         begin
            next_rdata[`VCR_STS_IGNORED_BIT] = ignored_seen;
            next_rdata[`VCR_STS_ROLE_BIT] = port_is_upstream;
            next_rdata[`VCR_STS_UNMAPPED_BIT] = unmapped_seen;
            next_rdata[`VCR_STS_LOCKED_BIT] = role_locked;
            next_rdata[`VCR_STS_CNT_MSB:`VCR_STS_CNT_LSB] = ignored_cnt;
         end
         `VCR_ADDR_DIAG_LAST:
         begin
            next_rdata = last_addr;
         end
         default:
         begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   // Read data is registered at the address-phase edge so the slave never
   // inserts wait states; the cost is that a read issued right behind a write
   // to the control register sees the status from before that write.
   // Unmapped addresses still answer OKAY with zero data, so software that
   // probes the map for optional registers never takes a bus fault.
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= `VCR_HRESP_OKAY;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= `VCR_HRESP_OKAY;
         if (rd_en)
         begin
            hrdata <= next_rdata;
         end
         else
         begin
            hrdata <= 32'h00000000;
         end
      end
   end

endmodule

// File: test/vcr_cap_regs_chk.sv
// Assertions on the AHB-Lite port of the capability register bank.
`timescale 1ns/1ps

module vcr_cap_regs_chk
(
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Role strap
   input wire port_upstream_pin,
   // AHB-Lite inputs
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   // AHB-Lite outputs
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp
);
   reg [2:0] rel_cnt;
   reg up_ok;
   reg dn_ok;
   wire cap_sel = hsel && htrans[1] && hready && haddr == 32'h00000210;
   wire settled = rel_cnt == 3'h7;

   // Only trust a role once the strap held one level while it settled.
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         rel_cnt <= 3'h0;
         up_ok <= port_upstream_pin;
         dn_ok <= !port_upstream_pin;
      end
      else
      begin
         if (!settled)
            rel_cnt <= rel_cnt + 3'h1;
         if (rel_cnt < 3'h5 && !port_upstream_pin)
            up_ok <= 1'b0;
         if (rel_cnt < 3'h5 && port_upstream_pin)
            dn_ok <= 1'b0;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_cap_rd;
      cap_sel && !hwrite;
   endsequence

   sequence s_cap_wr;
      cap_sel && hwrite;
   endsequence

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave stalled or answered with an error");
   a_arb_legal: assert property (s_cap_rd |=> hrdata[7:0] == 8'h03 || hrdata[7:0] == 8'h01)
      else $error("arbitration capability field has an illegal value");
   a_arb_bits: assert property (s_cap_rd |=> hrdata[7:2] == 6'h00)
      else $error("unsupported arbitration scheme advertised");
   a_rsvd_zero: assert property (s_cap_rd |=> hrdata[23:8] == 16'h0000)
      else $error("bits 23 to 8 of the capability read nonzero");
   a_offset_pair: assert property (s_cap_rd |=> (hrdata[31:24] == 8'h02) == (hrdata[7:0] == 8'h03))
      else $error("table offset does not match the port role");
   a_up_image: assert property (s_cap_rd ##0 (settled && up_ok) |=> hrdata == 32'h02000003)
      else $error("upstream capability word wrong");
   a_down_image: assert property (s_cap_rd ##0 (settled && dn_ok) |=> hrdata == 32'h00000001)
      else $error("downstream capability word wrong");
   a_wr_ignored: assert property (s_cap_rd ##2 s_cap_wr ##2 s_cap_rd |=> hrdata == $past(hrdata, 4))
      else $error("write changed the capability word");
endmodule

bind vcr_cap_regs vcr_cap_regs_chk u_chk (.core_clk(core_clk), .resetn(resetn),
   .port_upstream_pin(port_upstream_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp));

// File: test/vcr_cap_regs_tb.sv
// Self-checking bench for the capability register bank on its AHB-Lite port.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module vcr_cap_regs_tb;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic port_upstream_pin = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   wire [31:0] hrdata;
   wire hreadyout;
   wire hresp;
   wire hready = hreadyout;
   logic [31:0] exp_q[$];
   logic [31:0] exp_v;
   logic [31:0] ua;
   logic rd_phase = 1'b0;
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;
   int i;

   vcr_cap_regs dut (.core_clk(core_clk), .resetn(resetn),
      .port_upstream_pin(port_upstream_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));

   // Free-running 50 MHz clock.
   initial
   begin
      forever #10 core_clk = ~core_clk;
   end

   // Read data stands for one cycle only, so it is compared in its data phase.
   always @(posedge core_clk)
   begin
      if (rd_phase)
      begin
         exp_v = exp_q.pop_front();
         `CHK(hrdata, exp_v)
      end
      rd_phase <= hsel && htrans[1] && hready && !hwrite;
   end

   // A hung handshake would otherwise stall the run for ever.
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         fails++;
         conclude();
      end
   end

   task automatic conclude();
      begin
         $display("checks=%0d mismatches=%0d", total_checks, fails);
         if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   // One single word transfer; val is write data, or the expected read data.
   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] val);
      begin
         if (!wr)
            exp_q.push_back(val);
         hsel <= 1'b1;
         haddr <= addr;
         htrans <= 2'h2;
         hwrite <= wr;
         @(posedge core_clk);
         while (hready !== 1'b1)
            @(posedge core_clk);
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= wr ? val : $urandom;
         @(posedge core_clk);
         while (hready !== 1'b1)
            @(posedge core_clk);
      end
   endtask

   // The strap is held steady well past the settle window before any read.
   task automatic restart(input logic up);
      begin
         resetn <= 1'b0;
         port_upstream_pin <= up;
         repeat (3) @(posedge core_clk);
         resetn <= 1'b1;
         repeat (8) @(posedge core_clk);
      end
   endtask

   // Main sequence: upstream role, then a second reset into the downstream role.
   initial
   begin
      i = $urandom(47162);
      restart(1'b1);
      bus(1'b0, 32'h00000210, 32'h02000003);
      for (i = 0; i < 4; i++)
      begin
         bus(1'b1, 32'h00000210, $urandom);
         bus(1'b0, 32'h00000210, 32'h02000003);
      end
      bus(1'b0, 32'h00000304, 32'h0000040b);
      bus(1'b0, 32'h00000308, 32'h00000210);
      ua = 32'h00001000 | ($urandom & 32'hfffff0fc);
      bus(1'b0, ua, 32'h00000000);
      bus(1'b0, 32'h00000308, ua);
      bus(1'b0, 32'h00000304, 32'h0000040f);
      bus(1'b1, 32'h00000300, 32'h00000003);
      bus(1'b0, 32'h00000304, 32'h0000000a);
      bus(1'b0, 32'h00000300, 32'h00000002);
      bus(1'b1, 32'h00000300, 32'h00000000);
      bus(1'b1, 32'h00000210, $urandom);
      bus(1'b0, 32'h00000304, 32'h0000000b);
      restart(1'b0);
      bus(1'b0, 32'h00000210, 32'h00000001);
      for (i = 0; i < 4; i++)
      begin
         bus(1'b1, 32'h00000210, $urandom | 32'h00ffff00);
         bus(1'b0, 32'h00000210, 32'h00000001);
      end
      repeat (2) @(posedge core_clk);
      conclude();
   end
endmodule
